/* File: shared/indirect_address_mapper_consts.vh */
// Purpose: Shared constants for the indirect address mapper.
// Assumes: Included by its bare name from the rtl files.
// Notes: Definitions only, guarded against double inclusion.
`ifndef INDIRECT_ADDRESS_MAPPER_CONSTS_VH
`define INDIRECT_ADDRESS_MAPPER_CONSTS_VH

// Pointer region bounds
`define IAM_TRAD_LAST 16'h0FFF
`define IAM_LIN_BASE 16'h2000
`define IAM_LIN_LAST 16'h29AF
// Pointer bit that selects program flash
`define IAM_FLASH_BIT 15
// Linear region layout: RAM block size, block start in a bank, bank shift
`define IAM_GPR_BLOCK 12'h050
`define IAM_GPR_START 12'h020
`define IAM_BANK_SHIFT 7
// Bank offsets below this value are the data ports themselves
`define IAM_PORT_COUNT 7'h02
// Value returned where nothing is read
`define IAM_ZERO 8'h00
// Core clocks per instruction cycle
`define IAM_INSTR_CLKS 4

`endif

/* File: rtl/linear_translator.v */
// Purpose: Translate a linear-region pointer into a banked data address.
// Assumes: Pointer already known to lie inside the linear region.
// Notes: Pure combinational; division is by a constant, so it folds.
`timescale 1ns/1ps
`include "indirect_address_mapper_consts.vh"

module linear_translator (
    // Linear pointer in
    input wire [15:0] lin_ptr_i,
    // Banked data address out
    output wire [11:0] bank_addr_o
);

    wire [11:0] offset; // Distance from the region base
    wire [11:0] bank; // Bank number, quotient
    wire [11:0] remain; // Byte within the bank block
    wire [15:0] diff; // Full-width subtraction

    ////////////////////////////////////////////////////////////////////////
    // subtract, divide, add
    assign diff = lin_ptr_i - `IAM_LIN_BASE;
    assign offset = diff[11:0];
    assign bank = offset / `IAM_GPR_BLOCK;
    assign remain = offset % `IAM_GPR_BLOCK;
    // next bank block
    // Remainder never reaches the common bytes, so they stay unreachable
    assign bank_addr_o = (bank << `IAM_BANK_SHIFT) + `IAM_GPR_START + remain;

endmodule

/* File: rtl/indirect_address_mapper.v */
// Purpose: Route indirect data port accesses to RAM or program flash.
// Assumes: Core, RAM and flash share CLK_I; RAM and flash answer
//          in the cycle after their read strobe.
// Notes: One access at a time; requests while busy are ignored.
`timescale 1ns/1ps
`include "indirect_address_mapper_consts.vh"

module indirect_address_mapper #(
    parameter INSTR_CLKS = `IAM_INSTR_CLKS, // Clocks in one instruction cycle
    parameter CNT_W = 8 // Width of the extra-cycle counter
) (
    // Clock and reset
    input wire CLK_I,
    input wire SRST_I,
    // Core request side
    input wire [7:0] PTR_HIGH_I,
    input wire [7:0] PTR_LOW_I,
    input wire ACCESS_RD_I,
    input wire ACCESS_WR_I,
    input wire [7:0] WR_DATA_I,
    // Core answer side
    output reg [7:0] RD_DATA_O,
    output reg DONE_O,
    output wire BUSY_O,
    output wire STALL_O,
    // Data RAM side
    output reg [11:0] RAM_ADDR_O,
    output reg RAM_RD_O,
    output reg RAM_WR_O,
    output reg [7:0] RAM_WDATA_O,
    input wire [7:0] RAM_RDATA_I,
    // Program flash side
    output reg [14:0] FLASH_ADDR_O,
    output reg FLASH_RD_O,
    input wire [13:0] FLASH_RDATA_I
);

    // Sequencer states
    localparam ST_IDLE = 2'b00;
    localparam ST_ACCESS = 2'b01;
    localparam ST_CAPTURE = 2'b10;
    localparam ST_EXTRA = 2'b11;

    // Region codes of the decoded pointer
    localparam RG_RAM = 2'b00;
    localparam RG_FLASH = 2'b01;
    localparam RG_NONE = 2'b10;

    wire [15:0] pointer; // Full pointer value
    wire [11:0] lin_addr; // Linear region translated address
    wire req; // Any access request
    reg [1:0] region; // Region of the current pointer
    reg [11:0] ram_addr; // RAM address for the pointer
    reg port_self; // Pointer names a data port itself

    reg [1:0] state_ff, nxt_state; // Sequencer state
    reg [1:0] rg_ff, nxt_rg; // Region of the access in flight
    reg wr_ff, nxt_wr; // Access in flight is a write
    reg [CNT_W-1:0] cnt_ff, nxt_cnt; // Extra-cycle countdown
    reg [11:0] nxt_ram_addr; // Next RAM address output
    reg nxt_ram_rd, nxt_ram_wr; // Next RAM strobes
    reg [7:0] nxt_wdata; // Next RAM write data
    reg [14:0] nxt_flash_addr; // Next flash address output
    reg nxt_flash_rd; // Next flash strobe
    reg [7:0] nxt_rd_data; // Next read data
    reg nxt_done; // Next done pulse

    ////////////////////////////////////////////////////////////////////////
    // Pointer assembly and decode

    assign pointer = {PTR_HIGH_I, PTR_LOW_I};
    assign req = ACCESS_RD_I | ACCESS_WR_I;

    // Linear translation kept in its own module for clarity
    linear_translator u_lin (
        .lin_ptr_i(pointer),
        .bank_addr_o(lin_addr)
    );

    // Region decode, checked from the top bit downward
    always @* begin
        region = RG_NONE;
        ram_addr = 12'h000;
        port_self = 1'b0;
        if (pointer[`IAM_FLASH_BIT]) begin
            region = RG_FLASH;
        end else if (pointer <= `IAM_TRAD_LAST) begin
            region = RG_RAM;
            ram_addr = pointer[11:0];
            port_self = (pointer[6:0] < `IAM_PORT_COUNT);
        end else if (pointer >= `IAM_LIN_BASE && pointer <= `IAM_LIN_LAST) begin
            region = RG_RAM;
            ram_addr = lin_addr;
        end else begin
            region = RG_NONE;
        end
        // Self-addressed port behaves like empty memory
        if (port_self) begin
            region = RG_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next-state logic

    // Busy whenever an access is in flight; new requests are ignored until idle
    assign BUSY_O = (state_ff != ST_IDLE);
    // Stall marks every busy cycle of a flash access, ST_ACCESS through ST_EXTRA
    assign STALL_O = (state_ff != ST_IDLE) && (rg_ff == RG_FLASH);

    always @* begin
        nxt_state = state_ff;
        nxt_rg = rg_ff;
        nxt_wr = wr_ff;
        nxt_cnt = cnt_ff;
        nxt_ram_addr = RAM_ADDR_O;
        nxt_ram_rd = 1'b0;
        nxt_ram_wr = 1'b0;
        nxt_wdata = RAM_WDATA_O;
        nxt_flash_addr = FLASH_ADDR_O;
        nxt_flash_rd = 1'b0;
        nxt_rd_data = RD_DATA_O;
        nxt_done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Take a request; a write wins if both strobes arrive
                if (req) begin
                    nxt_state = ST_ACCESS;
                    nxt_rg = region;
                    nxt_wr = ACCESS_WR_I;
                    if (region == RG_RAM) begin
                        nxt_ram_addr = ram_addr;
                        nxt_ram_rd = ~ACCESS_WR_I;
                        nxt_ram_wr = ACCESS_WR_I;
                        nxt_wdata = WR_DATA_I;
                    end else if (region == RG_FLASH) begin
                        nxt_flash_addr = pointer[14:0];
                        nxt_flash_rd = ~ACCESS_WR_I;
                    end
                end
            end
            ST_ACCESS: begin
                // Strobes are out this cycle; answer comes next cycle
                nxt_state = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                // Capture the answer of the addressed store
                if (!wr_ff) begin
                    case (rg_ff)
                        RG_RAM: begin
                            nxt_rd_data = RAM_RDATA_I;
                        end
                        RG_FLASH: begin
                            nxt_rd_data = FLASH_RDATA_I[7:0];
                        end
                        default: begin
                            nxt_rd_data = `IAM_ZERO;
                        end
                    endcase
                end
                if (rg_ff == RG_FLASH) begin
                    nxt_state = ST_EXTRA;
                    nxt_cnt = INSTR_CLKS[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                end else begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                end
            end
            ST_EXTRA: begin
                if (cnt_ff == {CNT_W{1'b0}}) begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                // Unreachable codes fall back to idle
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // All state and outputs clear on synchronous reset, except rg_ff, which loads RG_NONE
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            state_ff <= ST_IDLE;
            rg_ff <= RG_NONE;
            wr_ff <= 1'b0;
            cnt_ff <= {CNT_W{1'b0}};
            RAM_ADDR_O <= 12'h000;
            RAM_RD_O <= 1'b0;
            RAM_WR_O <= 1'b0;
            RAM_WDATA_O <= 8'h00;
            FLASH_ADDR_O <= 15'h0000;
            FLASH_RD_O <= 1'b0;
            RD_DATA_O <= 8'h00;
            DONE_O <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rg_ff <= nxt_rg;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
            RAM_ADDR_O <= nxt_ram_addr;
            RAM_RD_O <= nxt_ram_rd;
            RAM_WR_O <= nxt_ram_wr;
            RAM_WDATA_O <= nxt_wdata;
            FLASH_ADDR_O <= nxt_flash_addr;
            FLASH_RD_O <= nxt_flash_rd;
            RD_DATA_O <= nxt_rd_data;
            DONE_O <= nxt_done;
        end
    end

endmodule

/* File: tb/iam_mem_model.sv */
// Purpose: Data RAM and program flash answering the mapper's strobes.
// Assumes: Data is due the cycle after a read strobe.
// Notes: Outside that cycle the data lines toggle, so stale data never matches.
`timescale 1ns/1ps
module iam_mem_model (
    input wire logic clk_i,
    input wire logic [11:0] ram_addr_i,
    input wire logic ram_rd_i,
    input wire logic [14:0] flash_addr_i,
    input wire logic flash_rd_i,
    output logic [7:0] ram_rdata_o,
    output logic [13:0] flash_rdata_o
);
    ////////////////////////////////////////////////////////////////////////
    // Contents are a pattern of the address, cheap to predict in the bench
    initial begin
        ram_rdata_o = 8'h00;
        flash_rdata_o = 14'h0000;
    end
    always @(posedge clk_i) begin
        ram_rdata_o <= ram_rd_i ? ram_addr_i[7:0] ^ {ram_addr_i[11:8], 4'h5} : ~ram_rdata_o;
        flash_rdata_o <= flash_rd_i ? {flash_addr_i[13:0]} ^ 14'h15A5 : ~flash_rdata_o;
    end
endmodule

/* File: tb/iam_props.sv */
// Purpose: Port-level properties of the indirect address mapper.
// Assumes: One clock; SRST_I synchronous, active high.
// Notes: A request counts only when BUSY_O is low.
`timescale 1ns/1ps
module iam_props #(parameter INSTR_CLKS = 4) (
    input wire CLK_I, input wire SRST_I,
    input wire [7:0] PTR_HIGH_I, input wire [7:0] PTR_LOW_I,
    input wire ACCESS_RD_I, input wire ACCESS_WR_I,
    input wire [7:0] RD_DATA_O, input wire DONE_O, input wire BUSY_O, input wire STALL_O,
    input wire [11:0] RAM_ADDR_O, input wire RAM_RD_O, input wire RAM_WR_O,
    input wire [7:0] RAM_RDATA_I, input wire [14:0] FLASH_ADDR_O,
    input wire FLASH_RD_O, input wire [13:0] FLASH_RDATA_I
);
    localparam int FL_GAP = INSTR_CLKS + 1;
    // Clocks from the first stall cycle to the DONE_O pulse of a flash access
    localparam int FL_END = INSTR_CLKS + 2;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire [15:0] ptr = {PTR_HIGH_I, PTR_LOW_I};
    wire take = !BUSY_O && (ACCESS_RD_I || ACCESS_WR_I);
    wire rd = take && !ACCESS_WR_I;
    wire trad_ok = ptr < 16'h1000 && ptr[6:0] >= 7'h02;
    wire lin = ptr >= 16'h2000 && ptr <= 16'h29AF;
    wire [15:0] off = ptr - 16'h2000;
    // Bank number times the bank span, plus block start and remainder
    wire [15:0] lin_w = (off / 16'h0050) * 16'h0080 + 16'h0020 + off % 16'h0050;
    wire zero = (ptr < 16'h1000 && ptr[6:0] < 7'h02) || (!ptr[15] && !trad_ok && !lin);
    ////////////////////////////////////////////////////////////////////////
    sequence s_rd_ram; rd && (trad_ok || lin) ##2 1; endsequence
    sequence s_fl_rd; rd && ptr[15] ##2 1; endsequence
    property p_trad; rd && trad_ok |=> RAM_RD_O && RAM_ADDR_O == $past(ptr[11:0]); endproperty
    property p_lin; take && lin |=> RAM_ADDR_O == $past(lin_w[11:0]); endproperty
    property p_ram_data; s_rd_ram |=> RD_DATA_O == $past(RAM_RDATA_I); endproperty
    property p_self_wr; take && ACCESS_WR_I && zero |=> !RAM_WR_O; endproperty
    property p_zero_rd; rd && zero |-> ##3 DONE_O && RD_DATA_O == 8'h00; endproperty
    property p_fl_addr;
        rd && ptr[15] |=> FLASH_RD_O && !RAM_RD_O && FLASH_ADDR_O == $past(ptr[14:0]);
    endproperty
    property p_fl_wr; take && ACCESS_WR_I && ptr[15] |=> !RAM_WR_O && !FLASH_RD_O; endproperty
    property p_fl_data; s_fl_rd |-> ##FL_GAP RD_DATA_O == $past(FLASH_RDATA_I[7:0], FL_GAP);
    endproperty
    property p_fl_late; take && ptr[15] |=> STALL_O ##FL_END DONE_O && !STALL_O; endproperty
    property p_ram_fast; take && !ptr[15] |-> ##3 DONE_O && !STALL_O; endproperty
    a_trad: assert property (p_trad) else $error("traditional address wrong");
    a_lin: assert property (p_lin) else $error("linear address wrong");
    a_ram_data: assert property (p_ram_data) else $error("ram data lost");
    a_self_wr: assert property (p_self_wr) else $error("write not dropped");
    a_zero_rd: assert property (p_zero_rd) else $error("zero read wrong");
    a_fl_addr: assert property (p_fl_addr) else $error("flash address wrong");
    a_fl_wr: assert property (p_fl_wr) else $error("flash write strobed");
    a_fl_data: assert property (p_fl_data) else $error("flash byte wrong");
    a_fl_late: assert property (p_fl_late) else $error("flash timing wrong");
    a_ram_fast: assert property (p_ram_fast) else $error("ram timing wrong");
endmodule
bind indirect_address_mapper iam_props #(.INSTR_CLKS(INSTR_CLKS)) i_iam_props (.CLK_I, .SRST_I,
    .PTR_HIGH_I, .PTR_LOW_I, .ACCESS_RD_I, .ACCESS_WR_I, .RD_DATA_O, .DONE_O, .BUSY_O,
    .STALL_O, .RAM_ADDR_O, .RAM_RD_O, .RAM_WR_O, .RAM_RDATA_I, .FLASH_ADDR_O, .FLASH_RD_O,
    .FLASH_RDATA_I);

/* File: tb/indirect_address_mapper_test.sv */
// Purpose: Self-checking bench for the indirect address mapper.
// Assumes: Inputs change on the falling edge only.
// Notes: Expected RAM and flash bytes follow the memory model's pattern.
`timescale 1ns/1ps
module indirect_address_mapper_test;
    logic clk = 1'b0, srst = 1'b1, a_rd = 1'b0, a_wr = 1'b0, sw;
    logic [15:0] ptr = 16'h0000;
    logic [7:0] wd = 8'h00, rdat, ram_q, ram_wd, swd;
    logic [11:0] ram_a, sa;
    logic [14:0] fl_a;
    logic [13:0] fl_q;
    logic done, busy, stall, r_rd, r_wr, f_rd;
    integer fail_count = 0, compares = 0, lat, nb, ns;
    indirect_address_mapper i_indirect_address_mapper (.CLK_I(clk), .SRST_I(srst),
        .PTR_HIGH_I(ptr[15:8]), .PTR_LOW_I(ptr[7:0]), .ACCESS_RD_I(a_rd), .ACCESS_WR_I(a_wr),
        .WR_DATA_I(wd), .RD_DATA_O(rdat), .DONE_O(done), .BUSY_O(busy), .STALL_O(stall),
        .RAM_ADDR_O(ram_a), .RAM_RD_O(r_rd), .RAM_WR_O(r_wr), .RAM_WDATA_O(ram_wd),
        .RAM_RDATA_I(ram_q), .FLASH_ADDR_O(fl_a), .FLASH_RD_O(f_rd), .FLASH_RDATA_I(fl_q));
    iam_mem_model i_iam_mem_model (.clk_i(clk), .ram_addr_i(ram_a), .ram_rd_i(r_rd),
        .flash_addr_i(fl_a), .flash_rd_i(f_rd), .ram_rdata_o(ram_q), .flash_rdata_o(fl_q));
    initial begin
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access: pulse the request, then wait for DONE_O, noting strobes
    task go(input logic wr, input logic [15:0] p);
        @(negedge clk);
        ptr = p;
        a_wr = wr;
        a_rd = !wr;
        @(negedge clk);
        {a_rd, a_wr, sw, lat, nb, ns} = {2'b00, 1'b0, 32'd1, 32'd0, 32'd0};
        while (done !== 1'b1 && lat < 40) begin
            if (r_rd === 1'b1 || r_wr === 1'b1) {sw, sa, swd} = {1'b1, ram_a, ram_wd};
            // Busy and stall cycles seen before the done pulse
            nb += (busy === 1'b1);
            ns += (stall === 1'b1);
            @(negedge clk);
            lat++;
        end
        if (lat >= 40) begin
            fail_count++;
            close_out;
        end
    endtask
    // Banked and linear reads land on the mapped RAM cell
    task t_ram(input logic [15:0] p, input logic [11:0] a);
        go(1'b0, p);
        chk(sw, 1'b1);
        chk(sa, a);
        chk(rdat, a[7:0] ^ {a[11:8], 4'h5});
        chk(lat, 3);
        chk(nb, 2);
        chk(ns, 0);
        chk(busy, 1'b0);
    endtask
    // Writes strobe the mapped RAM cell with the data and leave read data alone
    task t_ram_wr(input logic [15:0] p, input logic [11:0] a, input logic [7:0] d);
        logic [7:0] held;
        held = rdat;
        wd = d;
        go(1'b1, p);
        chk(sw, 1'b1);
        chk(sa, a);
        chk(swd, d);
        chk(rdat, held);
        chk(lat, 3);
    endtask
    // Port self-address and holes read zero, writes give no strobe
    task t_zero(input logic [15:0] p);
        go(1'b0, p);
        chk(rdat, 8'h00);
        go(1'b1, p);
        chk(sw, 1'b0);
    endtask
    // Flash reads give the low byte after one extra instruction cycle
    task t_flash;
        go(1'b0, 16'h8123);
        chk(rdat, 8'h23 ^ 8'hA5);
        chk(lat, 7);
        chk(ns, 6);
        chk(nb, 6);
        go(1'b1, 16'hFFFF);
        chk(sw, 1'b0);
        chk(lat, 7);
        chk(ns, 6);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        wd = 8'h3C;
        t_ram(16'h0045, 12'h045);
        t_ram(16'h0FFF, 12'hFFF);
        t_ram(16'h204F, 12'h06F);
        t_ram(16'h2050, 12'h0A0);
        t_ram(16'h29AF, 12'hF6F);
        t_ram_wr(16'h2050, 12'h0A0, 8'hA7);
        t_ram_wr(16'h0123, 12'h123, 8'h5E);
        t_zero(16'h0081);
        t_zero(16'h1000);
        t_zero(16'h29B0);
        t_flash;
        close_out;
    end
endmodule
